// ---- hw/adgt_device.sv ----
// Configuration registers, divided clock and test pattern output of the converter
`timescale 1ns/1ps
module adgt_device
  import adgt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  adgt_link_if.dev LINK,
  input wire logic [DATA_BITS-1:0] SAMPLE_IN,
  output logic [DATA_BITS-1:0] DATA_OUT,
  output logic DIVIDED_CLOCK,
  output logic [2:0] DRIVER_SELECT,
  output logic [2:0] CODING_SELECT,
  output logic DDR_ENABLE,
  output logic DLL_SLOW,
  output logic TEST_ACTIVE
);

  // ==========================================================
  // Helpers

  // Accepts the all-zero pin code or a single one-hot choice
  function automatic logic sel_valid(input logic [2:0] code);
    sel_valid = (code == SEL_PIN) || (code == DIV_BY1) || (code == DIV_BY2) || (code == DIV_BY4);
  endfunction

  // Resolves a select against its pin default
  function automatic logic [2:0] sel_resolve(input logic [2:0] code, input logic [2:0] pin_value);
    sel_resolve = (code == SEL_PIN) ? pin_value : code;
  endfunction

  // ==========================================================
  // Register state
  logic [7:0] advance_reg;
  logic [2:0] div_sel_reg;
  logic [2:0] drive_sel_reg;
  logic [2:0] coding_sel_reg;
  logic [7:0] timing_raw_reg;
  logic [7:0] timing_eff_reg;
  logic [7:0] test_ctl_reg;
  logic [7:0] word1_low_reg;
  logic [7:0] word1_high_reg;
  logic [7:0] word2_low_reg;
  logic [7:0] word2_high_reg;
  logic [7:0] rdata_reg;
  logic ack_reg;
  logic advance_pulse_reg;

  logic access;
  logic wr;
  logic soft_reset;
  logic [7:0] read_mux;

  // One access per request, answered the next cycle
  assign access = LINK.req && !ack_reg;
  assign wr = access && LINK.we;
  assign soft_reset = wr && (LINK.addr == ADDR_PORT_CONFIG) && LINK.wdata[SOFT_RESET_BIT];

  // ==========================================================
  // Link answer
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= BYTE_RESET;
    end
    else
    begin
      ack_reg <= access;
      if (access && !LINK.we)
        rdata_reg <= read_mux;
    end
  end

  assign LINK.ack = ack_reg;
  assign LINK.rdata = rdata_reg;

  // Read decode, unmapped offsets read zero
  always_comb
  begin
    case (LINK.addr)
      ADDR_DIV_ADVANCE: read_mux = advance_reg;
      ADDR_DIV_SELECT: read_mux = {5'h00, div_sel_reg};
      ADDR_FORMAT_SELECT: read_mux = {drive_sel_reg, 2'h0, coding_sel_reg};
      ADDR_TIMING_SELECT: read_mux = timing_raw_reg;
      ADDR_CONFIG_STATE: read_mux = timing_raw_reg ^ timing_eff_reg;
      ADDR_TEST_CONTROL: read_mux = test_ctl_reg;
      ADDR_WORD1_LOW: read_mux = word1_low_reg;
      ADDR_WORD1_HIGH: read_mux = word1_high_reg;
      ADDR_WORD2_LOW: read_mux = word2_low_reg;
      ADDR_WORD2_HIGH: read_mux = word2_high_reg;
      default: read_mux = BYTE_RESET;
    endcase
  end

  // ==========================================================
  // Retained selects, untouched by soft reset
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      div_sel_reg <= SEL_PIN;
      drive_sel_reg <= SEL_PIN;
      coding_sel_reg <= SEL_PIN;
    end
    else if (wr)
    begin
      if (LINK.addr == ADDR_DIV_SELECT && sel_valid(LINK.wdata[2:0]))
        div_sel_reg <= LINK.wdata[2:0];
      if (LINK.addr == ADDR_FORMAT_SELECT && sel_valid(LINK.wdata[DRIVE_LSB +: 3]))
        drive_sel_reg <= LINK.wdata[DRIVE_LSB +: 3];
      if (LINK.addr == ADDR_FORMAT_SELECT && sel_valid(LINK.wdata[2:0]))
        coding_sel_reg <= LINK.wdata[2:0];
    end
  end

  // ==========================================================
  // Soft-resettable registers
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      advance_reg <= BYTE_RESET;
      advance_pulse_reg <= 1'b0;
      test_ctl_reg <= BYTE_RESET;
      word1_low_reg <= BYTE_RESET;
      word1_high_reg <= BYTE_RESET;
      word2_low_reg <= BYTE_RESET;
      word2_high_reg <= BYTE_RESET;
    end
    else if (soft_reset)
    begin
      advance_reg <= BYTE_RESET;
      advance_pulse_reg <= 1'b0;
      test_ctl_reg <= BYTE_RESET;
      word1_low_reg <= BYTE_RESET;
      word1_high_reg <= BYTE_RESET;
      word2_low_reg <= BYTE_RESET;
      word2_high_reg <= BYTE_RESET;
    end
    else
    begin
      // Rising write of the advance bit fires one command
      advance_pulse_reg <= wr && LINK.addr == ADDR_DIV_ADVANCE && LINK.wdata[ADVANCE_BIT]
        && !advance_reg[ADVANCE_BIT];
      if (wr)
      begin
        case (LINK.addr)
          ADDR_DIV_ADVANCE: advance_reg <= LINK.wdata;
          ADDR_TEST_CONTROL: test_ctl_reg <= LINK.wdata;
          ADDR_WORD1_LOW: word1_low_reg <= LINK.wdata;
          ADDR_WORD1_HIGH: word1_high_reg <= LINK.wdata;
          ADDR_WORD2_LOW: word2_low_reg <= LINK.wdata;
          ADDR_WORD2_HIGH: word2_high_reg <= LINK.wdata;
          default: advance_reg <= advance_reg;
        endcase
      end
    end
  end

  // ==========================================================
  // Timing fields: a write toggles the live value by the written bits under TIMING_MASK
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      timing_raw_reg <= BYTE_RESET;
      timing_eff_reg <= TIMING_RESET;
    end
    else if (soft_reset)
    begin
      timing_raw_reg <= BYTE_RESET;
      timing_eff_reg <= TIMING_RESET;
    end
    else if (wr && LINK.addr == ADDR_TIMING_SELECT)
    begin
      timing_raw_reg <= LINK.wdata;
      timing_eff_reg <= timing_eff_reg ^ (LINK.wdata & TIMING_MASK);
    end
  end

  // ==========================================================
  // Divided clock with advance
  logic [2:0] div_eff;
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;

  assign div_eff = sel_resolve(div_sel_reg, PIN_DIV_DEFAULT);
  // Skipping one count brings the next rising edge one cycle earlier
  assign div_cnt_next = div_cnt_reg + ((advance_pulse_reg && div_eff == DIV_BY4) ? 2'h2 : 2'h1);

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      div_cnt_reg <= 2'h0;
      DIVIDED_CLOCK <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_next;
      case (div_eff)
        DIV_BY4: DIVIDED_CLOCK <= !div_cnt_next[1];
        DIV_BY2: DIVIDED_CLOCK <= !div_cnt_next[0];
        default: DIVIDED_CLOCK <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Test pattern words
  logic [WORD_BITS-1:0] word_one;
  logic [WORD_BITS-1:0] word_two;
  logic pattern_on;

  always_comb
  begin
    word_two = WORD_ZEROS;
    pattern_on = 1'b1;
    case (test_ctl_reg[3:0])
      TPAT_MID: word_one = WORD_MID;
      TPAT_POS: word_one = WORD_ONES;
      TPAT_NEG: word_one = WORD_ZEROS;
      TPAT_CHECKER:
      begin
        word_one = WORD_CHECK_A;
        word_two = WORD_CHECK_B;
      end
      TPAT_ONEZERO: word_one = WORD_ONES;
      TPAT_CUSTOM:
      begin
        word_one = {word1_high_reg, word1_low_reg};
        word_two = {word2_high_reg, word2_low_reg};
      end
      default:
      begin
        word_one = WORD_ZEROS;
        pattern_on = 1'b0;
      end
    endcase
  end

  // Test enable settles through a short pipeline before use
  logic [TEST_SETTLE_STAGES-1:0] test_pipe_reg;
  logic phase_reg;
  logic alternate;

  assign alternate = test_ctl_reg[TEST_MODE_LSB +: 2] == TMODE_ALTERNATE;

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      test_pipe_reg <= '0;
      phase_reg <= 1'b0;
    end
    else
    begin
      test_pipe_reg <= {test_pipe_reg[TEST_SETTLE_STAGES-2:0], pattern_on};
      phase_reg <= !phase_reg;
    end
  end

  // ==========================================================
  // Output data and mode pins
  logic [2:0] coding_eff;
  logic [DATA_BITS-1:0] coded;

  assign coding_eff = sel_resolve(coding_sel_reg, PIN_COD_DEFAULT);

  // Sample arrives in offset binary
  always_comb
  begin
    case (coding_eff)
      COD_TWOS: coded = {!SAMPLE_IN[DATA_BITS-1], SAMPLE_IN[DATA_BITS-2:0]};
      COD_GRAY: coded = SAMPLE_IN ^ (SAMPLE_IN >> 1);
      default: coded = SAMPLE_IN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DATA_OUT <= '0;
      TEST_ACTIVE <= 1'b0;
      DRIVER_SELECT <= PIN_DRV_DEFAULT;
      CODING_SELECT <= PIN_COD_DEFAULT;
      DDR_ENABLE <= 1'b1;
      DLL_SLOW <= 1'b0;
    end
    else
    begin
      TEST_ACTIVE <= test_pipe_reg[TEST_SETTLE_STAGES-1];
      if (test_pipe_reg[TEST_SETTLE_STAGES-1])
        DATA_OUT <= (alternate && phase_reg) ? word_two[WORD_BITS-1 -: DATA_BITS]
          : word_one[WORD_BITS-1 -: DATA_BITS];
      else
        DATA_OUT <= coded;
      DRIVER_SELECT <= sel_resolve(drive_sel_reg, PIN_DRV_DEFAULT);
      CODING_SELECT <= coding_eff;
      DDR_ENABLE <= timing_eff_reg[DDR_BIT];
      DLL_SLOW <= timing_eff_reg[DLL_BIT];
    end
  end

endmodule // adgt_device

// ---- hw/adgt_host.sv ----
// Controller that drives the configuration link on orders from an Avalon-MM port
`timescale 1ns/1ps
module adgt_host
  import adgt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  adgt_link_if.host LINK,
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  typedef enum {H_IDLE, H_ISSUE, H_WAIT} adgt_hstate_e;

  adgt_hstate_e state_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] result_reg;
  logic [9:0] rate_reg;
  logic [7:0] timing_reg;
  logic [2:0] op_reg;
  logic [1:0] step_reg;
  logic [7:0] first_read_reg;
  logic start;
  logic busy;
  logic take;

  assign busy = state_reg != H_IDLE;
  // Command writes stall while a sequence runs
  assign take = AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)
    && !(AVS_WRITE && AVS_ADDRESS == CTL_COMMAND && busy);
  assign start = take && AVS_WRITE && AVS_ADDRESS == CTL_COMMAND;

  // ==========================================================
  // Avalon slave: one answer cycle per accepted access
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
      addr_reg <= BYTE_RESET;
      wdata_reg <= BYTE_RESET;
      rate_reg <= '0;
      timing_reg <= TIMING_RESET;
    end
    else if (!AVS_WAITREQUEST)
      AVS_WAITREQUEST <= 1'b1;
    else if (take)
    begin
      AVS_WAITREQUEST <= 1'b0;
      if (AVS_WRITE)
      begin
        case (AVS_ADDRESS)
          CTL_LINK_ADDR: addr_reg <= AVS_WRITEDATA[7:0];
          CTL_LINK_WDATA: wdata_reg <= AVS_WRITEDATA[7:0];
          CTL_RATE: rate_reg <= AVS_WRITEDATA[9:0];
          CTL_TIMING: timing_reg <= AVS_WRITEDATA[7:0];
          default: addr_reg <= addr_reg;
        endcase
      end
      else
      begin
        case (AVS_ADDRESS)
          CTL_LINK_ADDR: AVS_READDATA <= {24'h0, addr_reg};
          CTL_LINK_WDATA: AVS_READDATA <= {24'h0, wdata_reg};
          CTL_STATUS: AVS_READDATA <= {16'h0, result_reg, 7'h0, busy};
          CTL_RATE: AVS_READDATA <= {22'h0, rate_reg};
          CTL_TIMING: AVS_READDATA <= {24'h0, timing_reg};
          default: AVS_READDATA <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Timing value the controller asks for
  logic [7:0] desired;
  logic dll_slow;

  assign dll_slow = rate_reg >= DLL_SLOW_MIN_MSPS && rate_reg < DLL_FAST_MIN_MSPS;
  always_comb
  begin
    desired = timing_reg;
    desired[DDR_BIT] = 1'b1;
    desired[DLL_BIT] = dll_slow;
  end

  // Last step of each command
  logic [1:0] last_step;
  always_comb
  begin
    case (op_reg)
      OP_ADVANCE: last_step = 2'h1;
      OP_TIMING: last_step = 2'h2;
      default: last_step = 2'h0;
    endcase
  end

  // ==========================================================
  // Link sequencer
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= H_IDLE;
      op_reg <= 3'h0;
      step_reg <= 2'h0;
      first_read_reg <= BYTE_RESET;
      result_reg <= BYTE_RESET;
      LINK.req <= 1'b0;
      LINK.we <= 1'b0;
      LINK.addr <= BYTE_RESET;
      LINK.wdata <= BYTE_RESET;
    end
    else
    begin
      case (state_reg)
        H_IDLE:
        begin
          if (start && AVS_WRITEDATA[2:0] >= OP_WRITE && AVS_WRITEDATA[2:0] <= OP_TIMING)
          begin
            op_reg <= AVS_WRITEDATA[2:0];
            step_reg <= 2'h0;
            state_reg <= H_ISSUE;
          end
        end
        H_ISSUE:
        begin
          LINK.req <= 1'b1;
          state_reg <= H_WAIT;
          case (op_reg)
            OP_WRITE:
            begin
              LINK.we <= 1'b1;
              LINK.addr <= addr_reg;
              LINK.wdata <= wdata_reg;
            end
            OP_READ:
            begin
              LINK.we <= 1'b0;
              LINK.addr <= addr_reg;
            end
            OP_ADVANCE:
            begin
              LINK.we <= 1'b1;
              LINK.addr <= ADDR_DIV_ADVANCE;
              LINK.wdata <= {7'h00, step_reg[0]};
            end
            default:
            begin
              LINK.we <= step_reg == 2'h2;
              LINK.addr <= (step_reg == 2'h1) ? ADDR_CONFIG_STATE : ADDR_TIMING_SELECT;
              LINK.wdata <= first_read_reg ^ result_reg ^ desired;
            end
          endcase
        end
        H_WAIT:
        begin
          if (LINK.ack)
          begin
            LINK.req <= 1'b0;
            if (!LINK.we)
            begin
              result_reg <= LINK.rdata;
              if (step_reg == 2'h0)
                first_read_reg <= LINK.rdata;
            end
            if (step_reg == last_step)
              state_reg <= H_IDLE;
            else
            begin
              step_reg <= step_reg + 2'h1;
              state_reg <= H_ISSUE;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

endmodule // adgt_host

// ---- hw/adgt_link_if.sv ----
// Register link between the controller and the configuration block
`timescale 1ns/1ps
interface adgt_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// ---- hw/adgt_pkg.sv ----
// Shared constants for the converter configuration block and its controller
package adgt_pkg;

  // ==========================================================
  // Register offsets on the configuration link
  localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_DIV_ADVANCE = 8'h71;
  localparam logic [7:0] ADDR_DIV_SELECT = 8'h72;
  localparam logic [7:0] ADDR_FORMAT_SELECT = 8'h73;
  localparam logic [7:0] ADDR_TIMING_SELECT = 8'h74;
  localparam logic [7:0] ADDR_CONFIG_STATE = 8'h75;
  localparam logic [7:0] ADDR_TEST_CONTROL = 8'hc0;
  localparam logic [7:0] ADDR_WORD1_LOW = 8'hc2;
  localparam logic [7:0] ADDR_WORD1_HIGH = 8'hc3;
  localparam logic [7:0] ADDR_WORD2_LOW = 8'hc4;
  localparam logic [7:0] ADDR_WORD2_HIGH = 8'hc5;

  // ==========================================================
  // Field positions
  localparam int SOFT_RESET_BIT = 5;
  localparam int ADVANCE_BIT = 0;
  localparam int DDR_BIT = 4;
  localparam int DLL_BIT = 6;
  localparam int DRIVE_LSB = 5;
  localparam int TEST_MODE_LSB = 6;
  localparam logic [7:0] TIMING_MASK = 8'h50;

  // ==========================================================
  // Select encodings (pin, then one-hot choices)
  localparam logic [2:0] SEL_PIN = 3'h0;
  localparam logic [2:0] DIV_BY1 = 3'h1;
  localparam logic [2:0] DIV_BY2 = 3'h2;
  localparam logic [2:0] DIV_BY4 = 3'h4;
  localparam logic [2:0] DRV_DIFF_2MA = 3'h1;
  localparam logic [2:0] DRV_DIFF_3MA = 3'h2;
  localparam logic [2:0] DRV_CMOS = 3'h4;
  localparam logic [2:0] COD_TWOS = 3'h1;
  localparam logic [2:0] COD_GRAY = 3'h2;
  localparam logic [2:0] COD_OFFSET = 3'h4;

  // Settings used when the select pins are absent
  localparam logic [2:0] PIN_DIV_DEFAULT = DIV_BY1;
  localparam logic [2:0] PIN_DRV_DEFAULT = DRV_DIFF_3MA;
  localparam logic [2:0] PIN_COD_DEFAULT = COD_TWOS;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TIMING_RESET = 8'h10;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================
  // Test patterns
  localparam logic [1:0] TMODE_STATIC = 2'h0;
  localparam logic [1:0] TMODE_ALTERNATE = 2'h1;
  localparam logic [3:0] TPAT_OFF = 4'h0;
  localparam logic [3:0] TPAT_MID = 4'h1;
  localparam logic [3:0] TPAT_POS = 4'h2;
  localparam logic [3:0] TPAT_NEG = 4'h3;
  localparam logic [3:0] TPAT_CHECKER = 4'h4;
  localparam logic [3:0] TPAT_ONEZERO = 4'h7;
  localparam logic [3:0] TPAT_CUSTOM = 4'h8;
  localparam logic [15:0] WORD_MID = 16'h8000;
  localparam logic [15:0] WORD_ONES = 16'hffff;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_CHECK_A = 16'haaaa;
  localparam logic [15:0] WORD_CHECK_B = 16'h5555;
  localparam int TEST_SETTLE_STAGES = 3;

  // ==========================================================
  // Converter data and DLL ranges
  localparam int DATA_BITS = 10;
  localparam int WORD_BITS = 16;
  localparam logic [9:0] DLL_SLOW_MIN_MSPS = 10'd40;
  localparam logic [9:0] DLL_FAST_MIN_MSPS = 10'd80;

  // ==========================================================
  // Controller register indices (word address on the Avalon port)
  localparam logic [2:0] CTL_LINK_ADDR = 3'h0;
  localparam logic [2:0] CTL_LINK_WDATA = 3'h1;
  localparam logic [2:0] CTL_COMMAND = 3'h2;
  localparam logic [2:0] CTL_STATUS = 3'h3;
  localparam logic [2:0] CTL_RATE = 3'h4;
  localparam logic [2:0] CTL_TIMING = 3'h5;

  // Controller commands
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_ADVANCE = 3'h3;
  localparam logic [2:0] OP_TIMING = 3'h4;

endpackage

// ---- tb/adc_global_config_test_pattern_tb.sv ----
// Testbench joining controller and configuration block
`timescale 1ns/1ps
module adc_global_config_test_pattern_tb
  import adgt_pkg::*;
;
  typedef struct packed {logic [7:0] v; logic [2:0] drv; logic [2:0] cod; logic [9:0] dout;} adgt_row_s;
  // ==========================================================
  // Signals and tables
  logic clock, resetn, avs_read, avs_write, divided_clock, ddr_enable, dll_slow, test_active, dc_prev;
  logic [2:0] avs_address, driver_select, coding_select;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [9:0] data_out, a, b;
  logic avs_waitrequest;
  logic [7:0] v;
  int n_fail, compares, cyc, t0, t1;
  adgt_row_s rows [5] = '{'{8'h21, DRV_DIFF_2MA, COD_TWOS, 10'h0c5}, '{8'h42, DRV_DIFF_3MA, COD_GRAY, 10'h3a7},
    '{8'h00, DRV_DIFF_3MA, COD_TWOS, 10'h0c5}, '{8'h84, DRV_CMOS, COD_OFFSET, 10'h2c5},
    '{8'h63, DRV_CMOS, COD_OFFSET, 10'h2c5}};
  logic [3:0] pc [6] = '{TPAT_MID, TPAT_POS, TPAT_NEG, TPAT_CUSTOM, 4'h5, TPAT_OFF};
  logic [15:0] pw [6] = '{WORD_MID, WORD_ONES, WORD_ZEROS, 16'hb3c5, 16'h0, 16'h0};
  logic [3:0] ac [3] = '{TPAT_CHECKER, TPAT_ONEZERO, TPAT_CUSTOM};
  logic [15:0] aw [3] = '{WORD_CHECK_A, WORD_ONES, 16'hb3c5};
  logic [15:0] bw [3] = '{WORD_CHECK_B, WORD_ZEROS, 16'h0f0f};
  adgt_link_if adgt_link_if_inst();
  adgt_device adgt_device_inst(.CLOCK(clock), .RESETN(resetn), .LINK(adgt_link_if_inst.dev),
    .SAMPLE_IN(10'h2c5), .DATA_OUT(data_out), .DIVIDED_CLOCK(divided_clock), .DRIVER_SELECT(driver_select),
    .CODING_SELECT(coding_select), .DDR_ENABLE(ddr_enable), .DLL_SLOW(dll_slow), .TEST_ACTIVE(test_active));
  adgt_host adgt_host_inst(.CLOCK(clock), .RESETN(resetn), .LINK(adgt_link_if_inst.host),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));
  adgt_chk adgt_chk_inst(.CLOCK(clock), .RESETN(resetn), .req(adgt_link_if_inst.req), .we(adgt_link_if_inst.we),
    .addr(adgt_link_if_inst.addr), .wdata(adgt_link_if_inst.wdata), .rdata(adgt_link_if_inst.rdata),
    .ack(adgt_link_if_inst.ack));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic avs(input logic wr, input logic [2:0] ad, input logic [31:0] d);
    @(posedge clock);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic lwr(input logic [7:0] la, input logic [7:0] ld);
    avs(1'b1, CTL_LINK_ADDR, {24'h0, la});
    avs(1'b1, CTL_LINK_WDATA, {24'h0, ld});
    avs(1'b1, CTL_COMMAND, {29'h0, OP_WRITE});
    repeat (6) @(posedge clock);
  endtask
  // Polls status until the link sequence has finished
  task automatic idle();
    do avs(1'b0, CTL_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic lrd(input logic [7:0] la);
    avs(1'b1, CTL_LINK_ADDR, {24'h0, la});
    avs(1'b1, CTL_COMMAND, {29'h0, OP_READ});
    idle();
    v = q[15:8];
  endtask
  task automatic rise(output int t);
    do @(posedge clock); while (!(divided_clock === 1'b1 && dc_prev === 1'b0));
    t = cyc;
  endtask
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Clock, cycle count and watchdog
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    dc_prev <= divided_clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {resetn, avs_read, avs_write, avs_address, avs_writedata, n_fail, compares, cyc} = '0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk({divided_clock, driver_select, coding_select, ddr_enable, dll_slow, test_active},
      {1'b1, PIN_DRV_DEFAULT, PIN_COD_DEFAULT, 3'h4});
    avs(1'b0, 3'h7, 32'h0);
    chk(q, 0);
    for (int i = 0; i < 5; i++)
    begin
      lwr(ADDR_FORMAT_SELECT, rows[i].v);
      chk({driver_select, coding_select, data_out}, {rows[i].drv, rows[i].cod, rows[i].dout});
    end
    lwr(ADDR_DIV_SELECT, {5'h0, DIV_BY2});
    rise(t0);
    rise(t1);
    chk(t1 - t0, 2);
    lwr(ADDR_DIV_SELECT, {5'h0, DIV_BY4});
    lwr(ADDR_DIV_SELECT, 8'h03);
    rise(t0);
    avs(1'b1, CTL_COMMAND, {29'h0, OP_ADVANCE});
    idle();
    rise(t1);
    chk((t1 - t0) % 4, 3);
    lwr(ADDR_WORD1_LOW, 8'hc5);
    lwr(ADDR_WORD1_HIGH, 8'hb3);
    lwr(ADDR_WORD2_LOW, 8'h0f);
    lwr(ADDR_WORD2_HIGH, 8'h0f);
    lrd(ADDR_WORD1_HIGH);
    chk(v, 8'hb3);
    for (int i = 0; i < 6; i++)
    begin
      lwr(ADDR_TEST_CONTROL, {4'h0, pc[i]});
      chk({test_active, data_out}, i < 4 ? {1'b1, pw[i][15:6]} : {1'b0, 10'h2c5});
    end
    for (int i = 0; i < 3; i++)
    begin
      lwr(ADDR_TEST_CONTROL, {TMODE_ALTERNATE, 2'h0, ac[i]});
      a = data_out;
      @(posedge clock);
      b = data_out;
      chk({a, b} == {aw[i][15:6], bw[i][15:6]} || {b, a} == {aw[i][15:6], bw[i][15:6]}, 1);
    end
    avs(1'b1, CTL_RATE, 32'd120);
    avs(1'b1, CTL_COMMAND, {29'h0, OP_TIMING});
    idle();
    chk({ddr_enable, dll_slow}, 2'h2);
    avs(1'b1, CTL_RATE, 32'd50);
    avs(1'b1, CTL_COMMAND, {29'h0, OP_TIMING});
    idle();
    chk({ddr_enable, dll_slow}, 2'h3);
    lwr(ADDR_PORT_CONFIG, 8'h20);
    chk({test_active, dll_slow, ddr_enable, driver_select, coding_select}, {3'h1, DRV_CMOS, COD_OFFSET});
    lrd(ADDR_DIV_SELECT);
    chk(v, 8'h04);
    lrd(ADDR_WORD1_HIGH);
    chk(v, 8'h00);
    conclude();
  end
endmodule // adc_global_config_test_pattern_tb

// ---- tb/adgt_chk.sv ----
// Protocol and sequence checker for the configuration link
`timescale 1ns/1ps
module adgt_chk
  import adgt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  // ==========================================================
  // Helper state
  logic adv_reg;
  logic [7:0] r74_reg, r75_reg;
  logic [1:0] seen_reg;
  logic wr74;
  assign wr74 = we && addr == ADDR_TIMING_SELECT;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  // Last advance bit and timing bytes read by the controller
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      adv_reg <= 1'b0;
      r74_reg <= 8'h00;
      r75_reg <= 8'h00;
      seen_reg <= 2'h0;
    end
    else if (ack)
    begin
      if (we && addr == ADDR_DIV_ADVANCE)
        adv_reg <= wdata[ADVANCE_BIT];
      if (!we && addr == ADDR_TIMING_SELECT)
        r74_reg <= rdata;
      if (!we && addr == ADDR_CONFIG_STATE)
        r75_reg <= rdata;
      seen_reg <= wr74 ? 2'h0 : seen_reg | {!we && addr == ADDR_CONFIG_STATE, !we && addr == ADDR_TIMING_SELECT};
    end
  end
  // ==========================================================
  // Assertions
  ack_follows_req_a: assert property (req && !ack |=> ack) else $error("ack late");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
  req_drop_a: assert property (ack |=> !req) else $error("req kept after ack");
  req_held_a: assert property (req && !ack |=> req && $stable({we, addr, wdata})) else $error("req moved");
  no_idle_ack_a: assert property (!req |=> !ack) else $error("ack unasked");
  rdata_hold_a: assert property (ack |=> $stable(rdata)) else $error("rdata moved");
  advance_order_a: assert property (req && we && addr == ADDR_DIV_ADVANCE && wdata[ADVANCE_BIT] |-> !adv_reg)
    else $error("advance one without zero");
  timing_xor_a: assert property (req && wr74 |-> seen_reg == 2'h3
    && wdata[DDR_BIT] == !(r74_reg[DDR_BIT] ^ r75_reg[DDR_BIT]))
    else $error("timing write wrong");
  // Main scenarios
  cover property (ack && we && addr == ADDR_DIV_ADVANCE && wdata[0]);
  cover property (ack && wr74);
  cover property (ack && !we);
endmodule // adgt_chk
